// ==== design/sdc_top.sv ====
// Purpose: Control and result forming for a primary and an auxiliary sigma-delta converter.
// Assumes: Filter words arrive on this clock as signed two's complement values.
// Notes:   Software restarts both converters by writing either control register.
// Overview of operation
// - Primary reference select bit set picks external reference, clear picks 1.25 V bandgap.
// - Primary channel code routes 1/2, 3/4, 2/2 shorted, or 3/2.
// - Primary unipolar gives zero for zero input; bipolar gives mid-scale.
// - Primary range code picks eight doubling spans; unipolar uses positive half.
// - Auxiliary reference select bit set picks external reference, clear picks bandgap.
// - Auxiliary channel code picks input3, input4, temperature sensor or input5 against ground.
// - Auxiliary unipolar gives zero 16-bit result; bipolar gives mid-scale.
// - Temperature result is mid-scale at zero degrees, one high-byte count per degree.
// - Auxiliary span is fixed at plus or minus reference, no range choice.
// - Results come at a programmable rate between 5.35 Hz and 105.03 Hz.
// - Inputs reverse each period; each filter word averages with the previous one.
// - First result after start or change needs two output periods.
// - Each converter sets its ready flag when a conversion completes.
`timescale 1ns/100ps
module sdc_top #(
    parameter int P_PERIOD_MIN_CYC = sdc_pkg::PERIOD_MIN_CYC,
    parameter int P_PERIOD_MAX_CYC = sdc_pkg::PERIOD_MAX_CYC
) (
    // Clock and reset.
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    // Special-function register port.
    input  wire logic [7:0]  i_sfr_addr,
    input  wire logic [7:0]  i_sfr_wdata,
    input  wire logic        i_sfr_wr,
    input  wire logic        i_sfr_rd,
    output logic      [7:0]  o_sfr_rdata,
    // Output period in system clock cycles.
    input  wire logic [21:0] i_period_cyc,
    // Decimation filter words.
    input  wire logic [23:0] i_pri_filt_data,
    input  wire logic [15:0] i_aux_filt_data,
    // Ready flag clears from the status register.
    input  wire logic        i_pri_ready_clr,
    input  wire logic        i_aux_ready_clr,
    // Primary front-end controls.
    output logic             o_pri_ext_ref_sel,
    output logic      [2:0]  o_pri_pos_sel,
    output logic      [2:0]  o_pri_neg_sel,
    output logic             o_pri_short,
    output logic      [2:0]  o_pri_range,
    // Auxiliary front-end controls.
    output logic             o_aux_ext_ref_sel,
    output logic      [2:0]  o_aux_pos_sel,
    output logic             o_aux_temp_sel,
    // Chop and filter timing.
    output logic             o_chop_phase,
    output logic             o_filt_dump,
    // Results and status.
    output logic      [23:0] o_pri_result,
    output logic      [15:0] o_aux_result,
    output logic             o_pri_result_ready,
    output logic             o_aux_result_ready
);

    if (P_PERIOD_MIN_CYC < 2 || P_PERIOD_MAX_CYC < P_PERIOD_MIN_CYC ||
        P_PERIOD_MAX_CYC >= (1 << sdc_pkg::PERIOD_W)) begin : g_bad_period
        $error("Output period limits do not fit the period counter.");
    end

    localparam logic [21:0] MIN_CYC = P_PERIOD_MIN_CYC[21:0];
    localparam logic [21:0] MAX_CYC = P_PERIOD_MAX_CYC[21:0];

    typedef struct packed {
        logic [7:0]  pri_ctrl;
        logic [7:0]  aux_ctrl;
        logic [7:0]  rdata;
        logic [21:0] tick_cnt;
        logic        chop;
        logic        dump;
        logic [23:0] pri_prev;
        logic [15:0] aux_prev;
        logic [1:0]  settle;
        logic [23:0] pri_res;
        logic [15:0] aux_res;
        logic        pri_rdy;
        logic        aux_rdy;
    } sdc_state_t;

    sdc_state_t st_q;
    sdc_state_t st_d;

    // Sum of two signed words halved without overflow.
    function automatic logic [23:0] sdc_avg(input logic [23:0] a, input logic [23:0] b);
        logic [24:0] sum;
        sum = {a[23], a} + {b[23], b};
        return sum[24:1];
    endfunction

    // Turns a signed averaged word into the output code.
    function automatic logic [23:0] sdc_code(input logic [23:0] avg, input logic uni);
        logic [23:0] res;
        res = {~avg[23], avg[22:0]};
        if (uni) begin
            if (avg[23]) begin
                res = sdc_pkg::PRI_ZERO_UNI;
            end else if (avg >= sdc_pkg::POS_HALF) begin
                res = sdc_pkg::FULL_CODE;
            end else begin
                res = {avg[22:0], 1'b0};
            end
        end
        return res;
    endfunction

    logic [21:0] period_lim;
    logic        wr_pri;
    logic        wr_aux;
    logic [23:0] pri_avg;
    logic [23:0] aux_avg;
    logic [23:0] aux_code;

    always_comb begin
        // Programmed period is held inside the documented rate span.
        period_lim = i_period_cyc;
        if (i_period_cyc < MIN_CYC) begin
            period_lim = MIN_CYC;
        end else if (i_period_cyc > MAX_CYC) begin
            period_lim = MAX_CYC;
        end
        wr_pri   = i_sfr_wr && (i_sfr_addr == sdc_pkg::PRI_CTRL_ADDR);
        wr_aux   = i_sfr_wr && (i_sfr_addr == sdc_pkg::AUX_CTRL_ADDR);
        pri_avg  = sdc_avg(i_pri_filt_data, st_q.pri_prev);
        aux_avg  = sdc_avg({i_aux_filt_data, 8'h00}, {st_q.aux_prev, 8'h00});
        aux_code = sdc_code(aux_avg, st_q.aux_ctrl[sdc_pkg::UNIPOLAR_BIT]);
    end

    always_comb begin
        st_d      = st_q;
        st_d.dump = 1'b0;

        if (wr_pri) begin
            st_d.pri_ctrl = i_sfr_wdata & sdc_pkg::PRI_CTRL_MASK;
        end
        if (wr_aux) begin
            st_d.aux_ctrl = i_sfr_wdata & sdc_pkg::AUX_CTRL_MASK;
        end

        if (i_sfr_rd) begin
            unique case (i_sfr_addr)
                sdc_pkg::PRI_CTRL_ADDR: st_d.rdata = st_q.pri_ctrl;
                sdc_pkg::AUX_CTRL_ADDR: st_d.rdata = st_q.aux_ctrl;
                default:                st_d.rdata = 8'h00;
            endcase
        end

        if (wr_pri || wr_aux) begin
            // A change restarts timing so stale filter words never average in.
            st_d.tick_cnt = '0;
            st_d.settle   = '0;
            st_d.chop     = 1'b0;
        end else if (st_q.tick_cnt >= period_lim - 22'h000001) begin
            st_d.tick_cnt = '0;
            st_d.dump     = 1'b1;
            st_d.chop     = ~st_q.chop;
            st_d.pri_prev = i_pri_filt_data;
            st_d.aux_prev = i_aux_filt_data;
            if (st_q.settle < sdc_pkg::SETTLE_OUTPUTS - 2'h1) begin
                st_d.settle = st_q.settle + 2'h1;
            end else begin
                st_d.settle  = sdc_pkg::SETTLE_OUTPUTS;
                st_d.pri_res = sdc_code(pri_avg, st_q.pri_ctrl[sdc_pkg::UNIPOLAR_BIT]);
                st_d.aux_res = aux_code[23:8];
                st_d.pri_rdy = 1'b1;
                st_d.aux_rdy = 1'b1;
            end
        end else begin
            st_d.tick_cnt = st_q.tick_cnt + 22'h000001;
        end

        // Clears lose to a completion in the same cycle.
        if (i_pri_ready_clr && !(st_d.dump && st_d.settle == sdc_pkg::SETTLE_OUTPUTS)) begin
            st_d.pri_rdy = 1'b0;
        end
        if (i_aux_ready_clr && !(st_d.dump && st_d.settle == sdc_pkg::SETTLE_OUTPUTS)) begin
            st_d.aux_rdy = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_q          <= '0;
            st_q.pri_ctrl <= sdc_pkg::PRI_CTRL_RST;
            st_q.aux_ctrl <= sdc_pkg::AUX_CTRL_RST;
        end else begin
            st_q <= st_d;
        end
    end

    logic [1:0] pri_ch;
    logic [1:0] aux_ch;

    always_comb begin
        pri_ch = st_q.pri_ctrl[sdc_pkg::CHAN_HI_BIT:sdc_pkg::CHAN_LO_BIT];
        aux_ch = st_q.aux_ctrl[sdc_pkg::CHAN_HI_BIT:sdc_pkg::CHAN_LO_BIT];
        o_pri_ext_ref_sel = st_q.pri_ctrl[sdc_pkg::EXT_REF_BIT];
        o_aux_ext_ref_sel = st_q.aux_ctrl[sdc_pkg::EXT_REF_BIT];
        o_pri_range = st_q.pri_ctrl[sdc_pkg::RANGE_HI_BIT:sdc_pkg::RANGE_LO_BIT];
        o_pri_short = 1'b0;
        unique case (pri_ch)
            sdc_pkg::CH_PAIR_A: begin
                o_pri_pos_sel = sdc_pkg::AIN_1;
                o_pri_neg_sel = sdc_pkg::AIN_2;
            end
            sdc_pkg::CH_PAIR_B: begin
                o_pri_pos_sel = sdc_pkg::AIN_3;
                o_pri_neg_sel = sdc_pkg::AIN_4;
            end
            sdc_pkg::CH_SHORT: begin
                o_pri_pos_sel = sdc_pkg::AIN_2;
                o_pri_neg_sel = sdc_pkg::AIN_2;
                o_pri_short   = 1'b1;
            end
            sdc_pkg::CH_PAIR_C: begin
                o_pri_pos_sel = sdc_pkg::AIN_3;
                o_pri_neg_sel = sdc_pkg::AIN_2;
            end
        endcase
        o_aux_temp_sel = (aux_ch == sdc_pkg::ACH_TEMP);
        unique case (aux_ch)
            2'h0:    o_aux_pos_sel = sdc_pkg::AIN_3;
            2'h1:    o_aux_pos_sel = sdc_pkg::AIN_4;
            2'h2:    o_aux_pos_sel = sdc_pkg::AIN_NONE;
            2'h3:    o_aux_pos_sel = sdc_pkg::AIN_5;
        endcase
    end

    assign o_sfr_rdata        = st_q.rdata;
    assign o_chop_phase       = st_q.chop;
    assign o_filt_dump        = st_q.dump;
    assign o_pri_result       = st_q.pri_res;
    assign o_aux_result       = st_q.aux_res;
    assign o_pri_result_ready = st_q.pri_rdy;
    assign o_aux_result_ready = st_q.aux_rdy;

endmodule

// ==== shared/sdc_pkg.sv ====
// Purpose: Shared constants for the sigma-delta converter control block.
// Assumes: 20 MHz system clock, 8-bit special-function register port.
// Notes:   Times are held in nanoseconds and turned into cycle counts here.
package sdc_pkg;

    // Register addresses and reset values.
    localparam logic [7:0] PRI_CTRL_ADDR = 8'hd2;
    localparam logic [7:0] AUX_CTRL_ADDR = 8'hd3;
    localparam logic [7:0] PRI_CTRL_RST  = 8'h07;
    localparam logic [7:0] AUX_CTRL_RST  = 8'h00;

    // Field positions shared by both control registers; the range field is in the primary register only.
    localparam int EXT_REF_BIT  = 6;
    localparam int CHAN_HI_BIT  = 5;
    localparam int CHAN_LO_BIT  = 4;
    localparam int UNIPOLAR_BIT = 3;
    localparam int RANGE_HI_BIT = 2;
    localparam int RANGE_LO_BIT = 0;

    // Writable bit masks; reserved bits stay zero.
    localparam logic [7:0] PRI_CTRL_MASK = 8'h7f;
    localparam logic [7:0] AUX_CTRL_MASK = 8'h78;

    // Analog input numbers driven onto the multiplexer selects.
    localparam logic [2:0] AIN_NONE = 3'h0;
    localparam logic [2:0] AIN_1    = 3'h1;
    localparam logic [2:0] AIN_2    = 3'h2;
    localparam logic [2:0] AIN_3    = 3'h3;
    localparam logic [2:0] AIN_4    = 3'h4;
    localparam logic [2:0] AIN_5    = 3'h5;

    // Channel codes.
    localparam logic [1:0] CH_PAIR_A  = 2'h0;
    localparam logic [1:0] CH_PAIR_B  = 2'h1;
    localparam logic [1:0] CH_SHORT   = 2'h2;
    localparam logic [1:0] CH_PAIR_C  = 2'h3;
    localparam logic [1:0] ACH_TEMP   = 2'h2;

    // Internal bandgap in millivolts and primary spans in microvolts.
    localparam int BANDGAP_MV = 1250;
    localparam int SPAN_MIN_UV = 20000;

    // Result coding constants.
    localparam logic [23:0] PRI_ZERO_UNI = 24'h000000;
    localparam logic [23:0] PRI_MID      = 24'h800000;
    localparam logic [15:0] AUX_ZERO_UNI = 16'h0000;
    localparam logic [15:0] AUX_MID      = 16'h8000;
    localparam logic [23:0] POS_HALF     = 24'h400000;
    localparam logic [23:0] FULL_CODE    = 24'hffffff;

    // Output period limits and clock.
    localparam longint CLK_PERIOD_NS = 50;
    localparam longint T_MIN_NS      = 9520000;
    localparam longint T_MAX_NS      = 186770000;
    localparam int PERIOD_MIN_CYC = int'((T_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int PERIOD_MAX_CYC = int'(T_MAX_NS / CLK_PERIOD_NS);
    localparam int PERIOD_W       = 22;

    // Filter outputs needed after a start or change before a result.
    localparam logic [1:0] SETTLE_OUTPUTS = 2'h2;

endpackage

// ==== sim/sdc_checker.sv ====
// Purpose: Port checker for the converter control block.
// Assumes: Period clamp of at least 4 cycles.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/100ps
module sdc_checker #(parameter int P_PERIOD_MIN_CYC = 4, parameter int P_PERIOD_MAX_CYC = 64) (
    // Clock, reset, register writes and auxiliary ready clear.
    input wire logic        i_clk,
    input wire logic        i_rst_b,
    input wire logic [7:0]  i_sfr_addr,
    input wire logic [7:0]  i_sfr_wdata,
    input wire logic        i_sfr_wr,
    input wire logic        i_aux_ready_clr,
    // Controls and results.
    input wire logic        o_pri_ext_ref_sel,
    input wire logic [2:0]  o_pri_range,
    input wire logic        o_aux_ext_ref_sel,
    input wire logic        o_chop_phase,
    input wire logic        o_filt_dump,
    input wire logic [23:0] o_pri_result,
    input wire logic [15:0] o_aux_result,
    input wire logic        o_pri_result_ready,
    input wire logic        o_aux_result_ready
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    wire wr_pri = i_sfr_wr && i_sfr_addr == sdc_pkg::PRI_CTRL_ADDR;
    wire wr_aux = i_sfr_wr && i_sfr_addr == sdc_pkg::AUX_CTRL_ADDR;
    property p_pri_ref; wr_pri |=> o_pri_ext_ref_sel == $past(i_sfr_wdata[6]); endproperty
    a_pri_ref: assert property (p_pri_ref) else $error("primary ref select");
    property p_pri_range; wr_pri |=> o_pri_range == $past(i_sfr_wdata[2:0]); endproperty
    a_pri_range: assert property (p_pri_range) else $error("primary range");
    property p_aux_ref; wr_aux |=> o_aux_ext_ref_sel == $past(i_sfr_wdata[6]); endproperty
    a_aux_ref: assert property (p_aux_ref) else $error("aux ref select");
    property p_chop; o_filt_dump && !$past(i_sfr_wr) |-> o_chop_phase != $past(o_chop_phase); endproperty
    a_chop: assert property (p_chop) else $error("chop phase held");
    property p_rdy_dump; $rose(o_pri_result_ready) |-> o_filt_dump; endproperty
    a_rdy_dump: assert property (p_rdy_dump) else $error("ready off period end");
    property p_settle; wr_pri || wr_aux |=> ##1 $stable(o_pri_result) [*6]; endproperty
    a_settle: assert property (p_settle) else $error("early result");
    property p_rdy_clr; i_aux_ready_clr |=> !o_aux_result_ready || o_filt_dump; endproperty
    a_rdy_clr: assert property (p_rdy_clr) else $error("ready not cleared");
    property p_hold; !o_filt_dump |-> $stable(o_pri_result) && $stable(o_aux_result); endproperty
    a_hold: assert property (p_hold) else $error("result moved");
    c_result: cover property (o_pri_result_ready && o_filt_dump);
    c_clear: cover property (i_aux_ready_clr && o_aux_result_ready);
    c_restart: cover property (wr_pri ##2 wr_aux);
endmodule
bind sdc_top sdc_checker #(.P_PERIOD_MIN_CYC(P_PERIOD_MIN_CYC), .P_PERIOD_MAX_CYC(P_PERIOD_MAX_CYC)) u_chk (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata), .i_sfr_wr(i_sfr_wr),
    .i_aux_ready_clr(i_aux_ready_clr), .o_pri_ext_ref_sel(o_pri_ext_ref_sel), .o_pri_range(o_pri_range),
    .o_aux_ext_ref_sel(o_aux_ext_ref_sel), .o_chop_phase(o_chop_phase), .o_filt_dump(o_filt_dump),
    .o_pri_result(o_pri_result), .o_aux_result(o_aux_result), .o_pri_result_ready(o_pri_result_ready),
    .o_aux_result_ready(o_aux_result_ready));

// ==== sim/sdc_front_model.sv ====
// Purpose: Chopped front end and filter stand-in for both converters.
// Assumes: Words are sampled at each period end.
// Notes:   A fixed offset changes sign with the chop phase.
`timescale 1ns/100ps
module sdc_front_model (
    // Chop phase and analog levels.
    input  wire logic        i_chop,
    input  wire logic [23:0] i_plev,
    input  wire logic [15:0] i_alev,
    // Filter words.
    output logic      [23:0] o_pword,
    output logic      [15:0] o_aword
);
    // Input reversal leaves an offset of opposite sign in each phase.
    assign o_pword = i_chop ? i_plev + 24'h000040 : i_plev - 24'h000040;
    assign o_aword = i_chop ? i_alev + 16'h0040 : i_alev - 16'h0040;
endmodule

// ==== sim/testbench.sv ====
// Purpose: Self-checking bench for the converter control block.
// Assumes: Periods of 8 cycles and both ends of a 4 to 64 clamp.
// Notes:   Expected codes are worked out from the input levels.
`timescale 1ns/100ps
module testbench;
    logic        i_clk = 1'b0, i_rst_b = 1'b0, wr = 1'b0, rd = 1'b0, pclr = 1'b0, aclr = 1'b0;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
    logic [23:0] plev = 24'h000000, pword, pres;
    logic [15:0] alev = 16'h0000, aword, ares;
    logic [21:0] per = 22'h000008;
    logic [2:0]  ppos, pneg, prng, apos;
    logic        pext, psh, aext, atemp, chop, dump, prdy, ardy;
    logic [2:0]  pos_t [4] = '{3'h1, 3'h3, 3'h2, 3'h3};
    logic [2:0]  neg_t [4] = '{3'h2, 3'h4, 3'h2, 3'h2};
    logic [2:0]  apos_t [4] = '{3'h3, 3'h4, 3'h0, 3'h5};
    int          num_errors = 0, checked = 0, cycles = 0, n;
    sdc_top #(.P_PERIOD_MIN_CYC(4), .P_PERIOD_MAX_CYC(64)) u_dut (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_sfr_addr(addr), .i_sfr_wdata(wdata), .i_sfr_wr(wr), .i_sfr_rd(rd), .o_sfr_rdata(rdata),
        .i_period_cyc(per), .i_pri_filt_data(pword), .i_aux_filt_data(aword), .i_pri_ready_clr(pclr),
        .i_aux_ready_clr(aclr), .o_pri_ext_ref_sel(pext), .o_pri_pos_sel(ppos), .o_pri_neg_sel(pneg),
        .o_pri_short(psh), .o_pri_range(prng), .o_aux_ext_ref_sel(aext), .o_aux_pos_sel(apos),
        .o_aux_temp_sel(atemp), .o_chop_phase(chop), .o_filt_dump(dump), .o_pri_result(pres),
        .o_aux_result(ares), .o_pri_result_ready(prdy), .o_aux_result_ready(ardy));
    sdc_front_model u_front (.i_chop(chop), .i_plev(plev), .i_alev(alev), .o_pword(pword), .o_aword(aword));
    always #25 i_clk = ~i_clk;
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            close_out();
        end
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge i_clk);
        wr <= 1'b0;
    endtask
    task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    // Clears both ready flags and counts edges from the last write or previous result until both are set again.
    task automatic wait_rdy(input logic [23:0] exp_n);
        @(posedge i_clk);
        pclr <= 1'b1;
        aclr <= 1'b1;
        n = 1;
        do begin
            @(posedge i_clk);
            pclr <= 1'b0;
            aclr <= 1'b0;
            n++;
            #1;
        end while ((prdy !== 1'b1 || ardy !== 1'b1 || n < 3) && n < 200);
        chk(24'(n), exp_n);
    endtask
    task automatic conv(input logic [7:0] pc, input logic [7:0] ac, input logic [23:0] pl,
                        input logic [15:0] al, input logic [23:0] ep, input logic [15:0] ea,
                        input logic [21:0] pp, input logic [23:0] ec);
        sfr_wr(sdc_pkg::AUX_CTRL_ADDR, ac);
        plev <= pl;
        alev <= al;
        per <= pp;
        sfr_wr(sdc_pkg::PRI_CTRL_ADDR, pc);
        for (int k = 0; k < 2; k++) begin
            wait_rdy(k == 0 ? {ec[22:0], 1'b0} : ec);
            chk(pres, ep);
            chk(24'(ares), 24'(ea));
        end
    endtask
    initial begin
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'b1;
        sfr_rd(sdc_pkg::PRI_CTRL_ADDR, 8'h07);
        sfr_rd(sdc_pkg::AUX_CTRL_ADDR, 8'h00);
        sfr_rd(8'hd4, 8'h00);
        sfr_wr(sdc_pkg::PRI_CTRL_ADDR, 8'hff);
        sfr_rd(sdc_pkg::PRI_CTRL_ADDR, 8'h7f);
        sfr_wr(sdc_pkg::AUX_CTRL_ADDR, 8'hff);
        sfr_rd(sdc_pkg::AUX_CTRL_ADDR, 8'h78);
        for (int i = 0; i < 8; i++) begin
            sfr_wr(sdc_pkg::PRI_CTRL_ADDR, {1'b0, i[0], i[1:0], 1'b0, i[2:0]});
            sfr_wr(sdc_pkg::AUX_CTRL_ADDR, {1'b0, ~i[0], i[1:0], 4'h0});
            #1 chk(pext, i[0]);
            chk(prng, i[2:0]);
            chk({ppos, pneg, psh}, {pos_t[i[1:0]], neg_t[i[1:0]], i[1:0] == 2'h2});
            chk(aext, 1'(~i[0]));
            chk({apos, atemp}, {apos_t[i[1:0]], i[1:0] == 2'h2});
        end
        conv(8'h07, 8'h00, 24'h000000, 16'h0000, 24'h800000, 16'h8000, 22'h8, 24'h8);
        conv(8'h0f, 8'h08, 24'h000000, 16'h0000, 24'h000000, 16'h0000, 22'h2, 24'h4);
        conv(8'h47, 8'h20, 24'hfffff0, 16'h1900, 24'h7ffff0, 16'h9900, 22'h8, 24'h8);
        conv(8'h0f, 8'h48, 24'h000100, 16'hfffb, 24'h000200, 16'h0000, 22'h100, 24'h40);
        // A reset in mid-run brings back the power-on state.
        @(posedge i_clk);
        i_rst_b <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'b1;
        #1 chk(pres, 24'h000000);
        chk({ares, prdy, ardy}, 24'h000000);
        sfr_rd(sdc_pkg::PRI_CTRL_ADDR, 8'h07);
        sfr_rd(sdc_pkg::AUX_CTRL_ADDR, 8'h00);
        close_out();
    end
endmodule
